// *** shared/srt_pkg.sv ***
// Constants shared by the four-stage shift register and its input synchroniser
`default_nettype none
package srt_pkg;
	localparam int SRT_STAGES = 4;
	localparam int SRT_SYNC_DEPTH = 2;
	localparam int SRT_PIN_COUNT = 8;
	localparam real SRT_CLK_PERIOD_NS = 10.0;
	localparam logic [SRT_PIN_COUNT-1:0] SRT_SYNC_RST = 8'h00;
	localparam logic SRT_EDGE_RST = 1'h0;
	localparam logic SRT_DRIVE_OFF = 1'h1;
	localparam int SRT_BIT_OE = 0;
	localparam int SRT_BIT_PAR = 1;
	localparam int SRT_BIT_SER = 5;
	localparam int SRT_BIT_LOAD = 6;
	localparam int SRT_BIT_CLK = 7;
	typedef logic [SRT_STAGES-1:0] srt_stage_t;
endpackage
`default_nettype wire

// *** test/srt_bus_partner.sv ***
// Shared bus and cascaded downstream register
`timescale 1ns/1ps
`default_nettype none
module srt_bus_partner
	import srt_pkg::*;
(
	// From the register, plus the shift clock pin
	input wire logic shiftClock,
	input wire srt_stage_t busOut,
	input wire logic busOutEn_n,
	// Bus and cascade
	output wire srt_stage_t bus,
	output var logic cascadeBit
);
	// Only one device on this bus, so no overlap
	assign bus = (busOutEn_n === SRT_DRIVE_OFF) ? 'z : busOut;
	// Released stage three gives the cascade no data
	always @(negedge shiftClock) cascadeBit <= bus[SRT_STAGES-1];
endmodule
`default_nettype wire

// *** test/test_srt_shift_register.sv ***
// Bench for the four-stage shift register
`timescale 1ns/1ps
`default_nettype none
module test_srt_shift_register;
	import srt_pkg::*;
	logic sysClk = 1'h0;
	logic srst = 1'h1;
	logic shiftClock = 1'h1;
	logic loadSelect = 1'h0;
	logic serialIn = 1'h0;
	logic outEnable = 1'h0;
	srt_stage_t parallelIn = 4'h0;
	srt_stage_t busOut;
	logic busOutEn_n, cascadeBit;
	wire srt_stage_t bus;
	int nFail = 0, samplesChecked = 0;
	srt_shift_register u_srt_shift_register (.sysClk(sysClk), .srst(srst),
		.shiftClock(shiftClock), .loadSelect(loadSelect), .serialIn(serialIn),
		.parallelIn(parallelIn), .outEnable(outEnable), .busOut(busOut),
		.busOutEn_n(busOutEn_n));
	srt_bus_partner u_srt_bus_partner (.shiftClock(shiftClock), .busOut(busOut),
		.busOutEn_n(busOutEn_n), .bus(bus), .cascadeBit(cascadeBit));
	initial forever #(SRT_CLK_PERIOD_NS / 2.0) sysClk = ~sysClk;
	task automatic check(input srt_stage_t exp);
		samplesChecked++;
		if (bus !== exp)
		begin
			nFail++;
			$display("ERROR %0t exp %h got %h", $time, exp, bus);
		end
	endtask
	task automatic checkCascade(input logic exp);
		samplesChecked++;
		if (cascadeBit !== exp)
		begin
			nFail++;
			$display("ERROR %0t cascade exp %h got %h", $time, exp, cascadeBit);
		end
	endtask
	// One falling pin edge; data held well past it
	task automatic pulse(input logic ld, input logic ser, input srt_stage_t par);
		loadSelect = ld;
		serialIn = ser;
		parallelIn = par;
		shiftClock = 1'h1;
		repeat (4) @(negedge sysClk);
		shiftClock = 1'h0;
		repeat (6) @(negedge sysClk);
	endtask
	task automatic t_load();
		outEnable = 1'h1;
		pulse(1'h1, 1'h1, 4'hA);
		check(4'hA);
	endtask
	// Cascade takes stage three as it stood before the edge
	task automatic t_shift();
		pulse(1'h0, 1'h1, 4'h0);
		check(4'h5);
		checkCascade(1'h1);
		pulse(1'h0, 1'h0, 4'hF);
		checkCascade(1'h0);
		pulse(1'h0, 1'h1, 4'hF);
		pulse(1'h0, 1'h1, 4'h0);
		pulse(1'h0, 1'h0, 4'h0);
		check(4'h6);
	endtask
	task automatic t_hiz();
		outEnable = 1'h0;
		pulse(1'h0, 1'h1, 4'h0);
		check(4'hZ);
		checkCascade(1'hZ);
		outEnable = 1'h1;
		repeat (5) @(negedge sysClk);
		check(4'hD);
	endtask
	// Rising edge and level changes leave the stages alone
	task automatic t_rise();
		shiftClock = 1'h0;
		repeat (4) @(negedge sysClk);
		loadSelect = 1'h1;
		parallelIn = 4'h3;
		shiftClock = 1'h1;
		repeat (6) @(negedge sysClk);
		parallelIn = 4'hC;
		serialIn = 1'h0;
		loadSelect = 1'h0;
		repeat (6) @(negedge sysClk);
		check(4'hD);
	endtask
	// Mid-run reset releases the bus but must leave the stages alone
	task automatic t_reset();
		srst = 1'h1;
		repeat (4) @(negedge sysClk);
		check(4'hZ);
		srst = 1'h0;
		repeat (3) @(negedge sysClk);
		check(4'hD);
		pulse(1'h1, 1'h0, 4'h9);
		check(4'h9);
	endtask
	task automatic finalReport();
		if (nFail == 0 && samplesChecked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(negedge sysClk);
		srst = 1'h0;
		repeat (3) @(negedge sysClk);
		t_load();
		t_shift();
		t_hiz();
		t_rise();
		t_reset();
		finalReport();
	end
	initial
	begin
		#20000;
		nFail++;
		finalReport();
	end
endmodule
`default_nettype wire

// *** verilog/srt_shift_register.sv ***
// Four-stage shift register with pin clock, parallel load and gated bus outputs
// Behaviour
// (R1) The register holds exactly four stages, zero to three, forming one shift register.
// (R2) Stages change only on a falling edge of the shift clock, never on a rise or level.
// (R3) With load select high at a falling edge, stage n takes parallel input n.
// (R4) With load select low at a falling edge, stage zero takes the serial input and the rest shift up.
// (R5) Load select, serial and parallel inputs matter only at the falling edge.
// (R6) With output drive enable high and srst low the bus shows the stages, otherwise it is released.
// (R7) The output drive enable never affects loading or shifting.
// (R8) While released, the last stage is not presented, so a cascaded register gets no valid data.
// (R9) Outside logic must never enable two devices sharing a bus at once.
// (R10) The stages have no reset and stay undefined until a load or four shifts.
`timescale 1ns/1ps
`default_nettype none
module srt_shift_register
	import srt_pkg::*;
(
	// Clock and reset
	input wire logic sysClk,
	input wire logic srst,
	// Pin inputs, asynchronous to sysClk
	input wire logic shiftClock,
	input wire logic loadSelect,
	input wire logic serialIn,
	input wire logic [SRT_STAGES-1:0] parallelIn,
	input wire logic outEnable,
	// Bus outputs
	output var srt_stage_t busOut,
	output var logic busOutEn_n
);
	import srt_pkg::*;

	logic [SRT_PIN_COUNT-1:0] pinSync;
	logic clkS;
	logic loadS;
	logic serS;
	logic oeS;
	srt_stage_t parS;
	logic clkPrev_reg;
	logic clkPrev_next;
	logic fall;
	logic rise;
	srt_stage_t stage_reg;
	srt_stage_t stage_next;
	logic drvOff_reg;
	logic drvOff_next;

	srt_sync uSync (
		.sysClk(sysClk),
		.srst(srst),
		.pinIn({shiftClock, loadSelect, serialIn, parallelIn, outEnable}),
		.pinSync(pinSync)
	);

	// All pins share one pipeline depth, so data stays aligned with the clock sample
	assign clkS = pinSync[SRT_BIT_CLK];
	assign loadS = pinSync[SRT_BIT_LOAD];
	assign serS = pinSync[SRT_BIT_SER];
	assign parS = pinSync[SRT_BIT_PAR +: SRT_STAGES];
	assign oeS = pinSync[SRT_BIT_OE];

	assign fall = clkPrev_reg & ~clkS; // R2
	assign rise = ~clkPrev_reg & clkS;

	// Edge detector
	always_comb
	begin
		clkPrev_next = srst ? SRT_EDGE_RST : clkS;
	end

	always_ff @(posedge sysClk)
	begin
		clkPrev_reg <= clkPrev_next;
	end

	// Stage update; enable and srst deliberately play no part
	always_comb
	begin
		stage_next = stage_reg; // R2 R5
		if (fall)
		begin
			if (loadS)
				stage_next = parS; // R3
			else
				stage_next = {stage_reg[SRT_STAGES-2:0], serS}; // R4 R1
		end
	end

	// No reset here: stages power up undefined
	always_ff @(posedge sysClk)
	begin
		stage_reg <= stage_next; // R10 R7
	end

	// Bus drive control
	always_comb
	begin
		drvOff_next = srst ? SRT_DRIVE_OFF : ~oeS; // R6 R8
	end

	always_ff @(posedge sysClk)
	begin
		drvOff_reg <= drvOff_next;
	end

	assign busOut = stage_reg; // R6
	assign busOutEn_n = drvOff_reg;

	default clocking cb @(posedge sysClk);
	endclocking
	default disable iff (srst);

	a_load_takes_parallel: assert property (fall && loadS |=> stage_reg == $past(parS)) // R3
		else $error("parallel load did not land");
	// Case equality: stages may still be unknown before the first load
	a_shift_moves_right: assert property (fall && !loadS |=> // R4
		stage_reg === {$past(stage_reg[SRT_STAGES-2:0]), $past(serS)})
		else $error("shift step wrong");
	a_hold_between_edges: assert property (!fall |=> stage_reg === $past(stage_reg)) // R5
		else $error("stages moved without falling edge");
	a_rise_no_change: assert property (rise |=> stage_reg === $past(stage_reg)) // R2
		else $error("stages moved on rising edge");
	a_four_step_fill: assert property (fall && !loadS |=> // R1
		stage_reg[SRT_STAGES-1] === $past(stage_reg[SRT_STAGES-2]))
		else $error("stage three not fed from stage two");
	a_drive_follows_oe: assert property (##1 1'h1 |-> busOutEn_n == !$past(oeS)) // R6
		else $error("drive enable not following pin");
	a_oe_change_holds: assert property ($changed(oeS) && !fall |=> // R7
		stage_reg === $past(stage_reg))
		else $error("enable change moved stages");
	a_reset_releases_bus: assert property (@(posedge sysClk) disable iff (1'h0) // R6
		srst |=> busOutEn_n)
		else $error("bus driven during reset");
	a_disabled_released: assert property (!oeS ##1 !oeS |-> busOutEn_n) // R8
		else $error("bus driven while disabled");
	a_oe_no_effect: assert property (fall && !oeS && loadS |=> stage_reg == $past(parS)) // R7
		else $error("disabled outputs blocked a load");
	a_reset_keeps_stages: assert property (@(posedge sysClk) disable iff (1'h0) // R10
		srst && !fall |=> stage_reg === $past(stage_reg))
		else $error("reset disturbed stages");

	c_load: cover property (fall && loadS);
	c_shift: cover property (fall && !loadS);
	c_load_hidden: cover property (fall && loadS && busOutEn_n);
	c_enable_window: cover property (busOutEn_n ##1 !busOutEn_n ##[1:20] busOutEn_n);
endmodule
`default_nettype wire

// *** verilog/srt_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module srt_sync
	import srt_pkg::*;
(
	// Clock and reset
	input wire logic sysClk,
	input wire logic srst,
	// Pins and their synchronised copy
	input wire logic [SRT_PIN_COUNT-1:0] pinIn,
	output var logic [SRT_PIN_COUNT-1:0] pinSync
);
	logic [SRT_PIN_COUNT-1:0] meta_reg;
	logic [SRT_PIN_COUNT-1:0] meta_next;
	logic [SRT_PIN_COUNT-1:0] sync_reg;
	logic [SRT_PIN_COUNT-1:0] sync_next;

	// First flop feeds only the second one
	always_comb
	begin
		meta_next = srst ? SRT_SYNC_RST : pinIn;
		sync_next = srst ? SRT_SYNC_RST : meta_reg;
	end

	always_ff @(posedge sysClk)
	begin
		meta_reg <= meta_next;
		sync_reg <= sync_next;
	end

	assign pinSync = sync_reg;
endmodule
`default_nettype wire
